// ==== design/tw_pkg.sv ====
package tw_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_MS  = 10;
  localparam int PROG_CYC      = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SEL_LOW_NS    = 250;
  localparam int SEL_LOW_CYC   = (SEL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CNT_W    = 21;

  // ==========================================================
  // Array geometry
  localparam int WORDS        = 1024;
  localparam int WIDX_W       = 10;
  localparam logic [4:0] ADDR8_W  = 5'h0B;
  localparam logic [4:0] ADDR16_W = 5'h0A;
  localparam logic [4:0] DATA8_W  = 5'h08;
  localparam logic [4:0] DATA16_W = 5'h10;
  localparam logic [9:0] LAST_WIDX = 10'h3FF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // ==========================================================
  // Opcodes and extended codes
  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_DIS  = 2'h0;
  localparam logic [1:0] EXT_WALL = 2'h1;
  localparam logic [1:0] EXT_EALL = 2'h2;
  localparam logic [1:0] EXT_EN   = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC  = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_READ = 3'b100,
    ST_HOLD = 3'b101
  } tw_state_t;

  typedef struct packed {
    tw_state_t   st;
    logic [4:0]  cnt;
    logic [1:0]  op;
    logic [10:0] addr;
    logic [15:0] data;
    logic        w16;
    logic        en;
    logic        sel_q;
    logic        shclk_q;
    logic        dout;
    logic        doe;
    logic        stat;
    logic        sweep;
    logic [9:0]  sidx;
    logic [15:0] pat;
  } tw_core_t;

  typedef struct packed {
    logic [PROG_CNT_W-1:0] cnt;
    logic                  busy;
  } tw_timer_t;

endpackage : tw_pkg

// ==== design/tw_prog_if.sv ====
interface tw_prog_if;
  logic start;
  logic busy;
  modport core  (output start, input busy);
  modport timer (input start, output busy);
endinterface : tw_prog_if

// ==== design/tw_sync.sv ====
module tw_sync #(
  parameter int N = 4
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Data
  input  wire logic [N-1:0] d,
  output logic      [N-1:0] q
);

  // ==========================================================
  // Two flop synchroniser
  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] hold;
  } tw_sync_t;

  tw_sync_t s_r;
  tw_sync_t s_nxt;

  always_comb begin
    s_nxt.meta = d;
    s_nxt.hold = s_r.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.hold;

endmodule : tw_sync

// ==== design/tw_prog_timer.sv ====
module tw_prog_timer
  import tw_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Program cycle handshake
  tw_prog_if.timer  prog
);

  tw_timer_t s_r;
  tw_timer_t s_nxt;

  // ==========================================================
  // Self-timed cycle counter
  always_comb begin
    s_nxt = s_r;
    if (prog.start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt  = PROG_CNT_W'(PROG_CYCLES - 1);
    end else if (s_r.busy) begin
      if (s_r.cnt == '0) begin
        s_nxt.busy = 1'b0;
      end else begin
        s_nxt.cnt = s_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prog.busy = s_r.busy;

endmodule : tw_prog_timer

// ==== design/tw_eeprom_port.sv ====
// Overview of operation
// R1: Frame opens on select rise, lead bit
// R2: Opcode 10 reads, 11 or 10 address bits
// R3: Read sends dummy zero, then word
// R4: Output changes on shift clock rising edges
// R5: Extended code 11 enables programming
// R6: Extended code 00 disables programming
// R7: Programming disabled after reset
// R8: Enable persists until disable command
// R9: Programming commands ignored while disabled
// R10: Opcode 11 erases word to ones
// R11: Erase starts after address decode
// R12: Opcode 01 writes data, no pre-erase
// R13: Write starts after last data bit
// R14: Select rise while busy shows status
// R15: No status if cycle already ended
// R16: Extended code 10 erases whole array
// R17: Extended code 01 writes whole array
// R18: Read works in either enable state
// R19: Host should disable after programming
// R20: Output released while select is low
// R21: Width select high gives 16-bit words
// R22: Inputs sampled on rising edge, MSB first
// R23: No new instruction while cycle runs
module tw_eeprom_port
  import tw_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Serial pins from host
  input  wire logic select,
  input  wire logic shift_clock,
  input  wire logic serial_in,
  input  wire logic width_select,
  // Serial output pin
  output logic      data_out,
  output logic      data_out_oe
);

  // ==========================================================
  // Pin synchronisers
  logic [3:0] pins_s;
  logic       sel_s;
  logic       shclk_s;
  logic       sdin_s;
  logic       w16_s;

  tw_sync #(.N(4)) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .d       ({select, shift_clock, serial_in, width_select}),
    .q       (pins_s)
  );

  assign sel_s = pins_s[3];
  assign shclk_s = pins_s[2];
  assign sdin_s  = pins_s[1];
  assign w16_s = pins_s[0];

  // ==========================================================
  // Self-timed cycle
  tw_prog_if prog ();

  tw_prog_timer #(.PROG_CYCLES(PROG_CYCLES)) u_timer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .prog    (prog.timer)
  );

  // ==========================================================
  // Helpers
  function automatic logic [9:0] widx_of(input logic [10:0] a, input logic w16);
    widx_of = w16 ? a[9:0] : a[10:1];
  endfunction : widx_of

  function automatic logic [1:0] lead2(input logic [10:0] a, input logic w16);
    lead2 = w16 ? a[9:8] : a[10:9];
  endfunction : lead2

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [10:0] a,
                                        input logic w16, input logic [15:0] d);
    if (w16) begin
      merge = d;
    end else if (a[0]) begin
      merge = {d[7:0], old[7:0]};
    end else begin
      merge = {old[15:8], d[7:0]};
    end
  endfunction : merge

  // ==========================================================
  // Storage array
  logic [15:0] mem [0:WORDS-1];
  logic        we;
  logic [9:0]  widx;
  logic [15:0] wdat;

  function automatic logic [15:0] fetch(input logic [15:0] w, input logic [10:0] a, input logic w16);
    if (w16) begin
      fetch = w;
    end else if (a[0]) begin
      fetch = {w[15:8], 8'h00};
    end else begin
      fetch = {w[7:0], 8'h00};
    end
  endfunction : fetch

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[widx] <= wdat;
    end
  end

  // ==========================================================
  // Instruction engine
  tw_core_t    s_r;
  tw_core_t    s_nxt;
  logic        shclk_rise;
  logic        sel_rise;
  logic        en_hit;
  logic        dis_hit;
  logic        rd_dummy;
  logic [10:0] addr_n;
  logic [10:0] addr_inc;
  logic [15:0] data_n;
  logic [4:0]  aw;
  logic [4:0]  dw;
  logic [15:0] rd_word;
  logic [15:0] rd_nxt;

  always_comb begin
    s_nxt       = s_r;
    we          = 1'b0;
    widx        = '0;
    wdat        = '0;
    prog.start  = 1'b0;
    en_hit      = 1'b0;
    dis_hit     = 1'b0;
    rd_dummy    = 1'b0;
    shclk_rise  = shclk_s && !s_r.shclk_q;
    sel_rise    = sel_s && !s_r.sel_q;
    addr_n      = {s_r.addr[9:0], sdin_s};
    data_n      = {s_r.data[14:0], sdin_s};
    // R21: word width from width select
    aw          = s_r.w16 ? ADDR16_W : ADDR8_W;
    dw          = s_r.w16 ? DATA16_W : DATA8_W;
    addr_inc    = s_r.w16 ? {1'b0, s_r.addr[9:0] + 10'h001} : s_r.addr + 11'h001;
    rd_word     = fetch(mem[widx_of(addr_n, s_r.w16)], addr_n, s_r.w16);
    rd_nxt      = fetch(mem[widx_of(addr_inc, s_r.w16)], addr_inc, s_r.w16);
    s_nxt.shclk_q = shclk_s;
    s_nxt.sel_q = sel_s;

    // R16: array sweep, one word per clock
    if (s_r.sweep) begin
      we         = 1'b1;
      widx       = s_r.sidx;
      wdat       = s_r.pat;
      s_nxt.sidx = s_r.sidx + 10'h001;
      if (s_r.sidx == LAST_WIDX) begin
        s_nxt.sweep = 1'b0;
      end
    end

    if (!sel_s) begin
      // R20: release output when deselected
      s_nxt.st   = ST_IDLE;
      s_nxt.doe  = 1'b0;
      s_nxt.stat = 1'b0;
    end else if (sel_rise) begin
      // R1: fresh frame on select rise
      // R15: status only when still busy
      s_nxt.st   = ST_IDLE;
      s_nxt.w16  = w16_s;
      s_nxt.stat = prog.busy;
      s_nxt.doe  = prog.busy;
      s_nxt.dout = 1'b0;
    end else if (s_r.stat) begin
      // R14: busy low, ready high
      s_nxt.dout = !prog.busy;
    end else if (shclk_rise && !prog.busy) begin
      // R23: decode only when idle
      // R22: sample on rising edge, MSB first
      case (s_r.st)
        ST_IDLE: begin
          if (sdin_s) begin
            s_nxt.st  = ST_OPC;
            s_nxt.cnt = '0;
          end
        end
        ST_OPC: begin
          s_nxt.op = {s_r.op[0], sdin_s};
          if (s_r.cnt == 5'h01) begin
            s_nxt.st   = ST_ADDR;
            s_nxt.cnt  = '0;
            s_nxt.addr = '0;
          end else begin
            s_nxt.cnt = s_r.cnt + 5'h01;
          end
        end
        ST_ADDR: begin
          s_nxt.addr = addr_n;
          if (s_r.cnt != aw - 5'h01) begin
            s_nxt.cnt = s_r.cnt + 5'h01;
          end else begin
            s_nxt.cnt = '0;
            s_nxt.st  = ST_HOLD;
            case (s_r.op)
              OP_READ: begin
                // R2: read decode
                // R18: independent of enable state
                // R3: dummy zero first
                rd_dummy   = 1'b1;
                s_nxt.st   = ST_READ;
                s_nxt.dout = 1'b0;
                s_nxt.doe  = 1'b1;
                s_nxt.data = rd_word;
              end
              OP_ERASE: begin
                // R9: gated by enable
                // R10: word to ones
                // R11: starts at address decode
                if (s_r.en) begin
                  we         = 1'b1;
                  widx       = widx_of(addr_n, s_r.w16);
                  wdat       = merge(mem[widx_of(addr_n, s_r.w16)], addr_n, s_r.w16, ERASED_WORD);
                  prog.start = 1'b1;
                end
              end
              OP_WRITE: begin
                s_nxt.st = ST_DATA;
              end
              default: begin
                case (lead2(addr_n, s_r.w16))
                  EXT_EN: begin
                    // R5: enable programming
                    en_hit   = 1'b1;
                    s_nxt.en = 1'b1;
                  end
                  EXT_DIS: begin
                    // R6: disable programming
                    // R8: only this command clears enable
                    dis_hit  = 1'b1;
                    s_nxt.en = 1'b0;
                  end
                  EXT_EALL: begin
                    // R16: erase all gated by enable
                    if (s_r.en) begin
                      s_nxt.sweep = 1'b1;
                      s_nxt.sidx  = '0;
                      s_nxt.pat   = ERASED_WORD;
                      prog.start  = 1'b1;
                    end
                  end
                  default: begin
                    s_nxt.st = ST_DATA;
                  end
                endcase
              end
            endcase
          end
        end
        ST_DATA: begin
          s_nxt.data = data_n;
          if (s_r.cnt != dw - 5'h01) begin
            s_nxt.cnt = s_r.cnt + 5'h01;
          end else begin
            s_nxt.st = ST_HOLD;
            // R13: cycle starts after last data bit
            if (s_r.en) begin
              prog.start = 1'b1;
              if (s_r.op == OP_WRITE) begin
                // R12: direct overwrite
                we   = 1'b1;
                widx = widx_of(s_r.addr, s_r.w16);
                wdat = merge(mem[widx_of(s_r.addr, s_r.w16)], s_r.addr, s_r.w16, data_n);
              end else begin
                // R17: same pattern to every word
                s_nxt.sweep = 1'b1;
                s_nxt.sidx  = '0;
                s_nxt.pat   = s_r.w16 ? data_n : {data_n[7:0], data_n[7:0]};
              end
            end
          end
        end
        ST_READ: begin
          // R4: shift out on rising edge
          if (s_r.cnt == dw) begin
            s_nxt.addr = addr_inc;
            s_nxt.dout = rd_nxt[15];
            s_nxt.data = {rd_nxt[14:0], 1'b0};
            s_nxt.cnt  = 5'h01;
          end else begin
            s_nxt.dout = s_r.data[15];
            s_nxt.data = {s_r.data[14:0], 1'b0};
            s_nxt.cnt  = s_r.cnt + 5'h01;
          end
        end
        ST_HOLD: begin
          s_nxt.st = ST_HOLD;
        end
        default: begin
          s_nxt.st = ST_IDLE;
        end
      endcase
    end
  end

  // R7: reset leaves programming disabled
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign data_out    = s_r.dout;
  assign data_out_oe = s_r.doe;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_oe_release: assert property (!sel_s |=> !data_out_oe) // R20
    else $error("output not released while deselected");
  chk_powerup_off: assert property ($past(!rst_b) |-> !s_r.en) // R7
    else $error("programming enabled after reset");
  chk_read_dummy: assert property (rd_dummy |=> data_out_oe && !data_out) // R3
    else $error("read dummy bit missing");
  chk_read_edge: assert property (s_r.st == ST_READ && $changed(data_out) && !$changed(s_r.st)
                                  |-> $past(shclk_rise)) // R4
    else $error("read data changed without shift edge");
  chk_enable_cmd: assert property (en_hit |=> s_r.en) // R5
    else $error("enable command not taken");
  chk_disable_cmd: assert property (dis_hit |=> !s_r.en) // R6
    else $error("disable command not taken");
  chk_enable_hold: assert property (s_r.en && !dis_hit |=> s_r.en) // R8
    else $error("enable lost without disable");
  chk_prog_gate: assert property (prog.start |-> s_r.en) // R9
    else $error("programming started while disabled");
  chk_late_status: assert property (sel_rise && !prog.busy && !prog.start |=> !data_out_oe) // R15
    else $error("status shown after cycle ended");
  chk_status_val: assert property (s_r.stat ##1 s_r.stat |-> data_out == !$past(prog.busy)) // R14
    else $error("status level wrong");
  chk_busy_span: assert property (prog.start |=> prog.busy [*8]) // R13
    else $error("program cycle too short");
  chk_busy_block: assert property (prog.busy && s_r.st == ST_IDLE && sel_s && !sel_rise
                                   |=> s_r.st == ST_IDLE) // R23
    else $error("instruction accepted while busy");

endmodule : tw_eeprom_port

// ==== verif/tw_host_model.sv ====
module tw_host_model (
  // Host pins
  output logic      select,
  output logic      shift_clock,
  output logic      serial_in,
  // Resolved device output
  input  wire logic dout_w
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    select      = 1'h0;
    shift_clock = 1'h0;
    serial_in   = 1'h1;
  end

  // ====================================
  // Bit level
  // data set, rising edge samples
  task automatic send_bit(input logic b);
    serial_in = b;
    #62.5;
    shift_clock = 1'h1;
    #62.5;
    shift_clock = 1'h0;
  endtask : send_bit

  task automatic rd_bit(output logic b);
    #62.5;
    shift_clock = 1'h1;
    #62.5;
    b = dout_w;
    shift_clock = 1'h0;
  endtask : rd_bit

  // ====================================
  // Frames
  // select rise, lead bit, opcode
  task automatic command(input logic [1:0] op, input logic [10:0] addr, input logic w16);
    select = 1'h1;
    #62.5;
    send_bit(1'h1);
    send_bit(op[1]);
    send_bit(op[0]);
    for (int i = (w16 ? 10'd9 : 10'd10); i >= 0; i--) begin
      send_bit(addr[i]);
    end
  endtask : command

  task automatic send_word(input logic [15:0] d, input logic w16);
    for (int i = (w16 ? 15 : 7); i >= 0; i--) begin
      send_bit(d[i]);
    end
  endtask : send_word

  task automatic read_word(input logic w16, output logic dummy, output logic [15:0] d);
    dummy = dout_w;
    d = 16'h0000;
    for (int i = (w16 ? 15 : 7); i >= 0; i--) begin
      rd_bit(d[i]);
    end
  endtask : read_word

  // select low for 250 ns or more
  task automatic end_frame;
    serial_in = ~serial_in;
    select = 1'h0;
    #300;
  endtask : end_frame

  task automatic status_rise;
    select = 1'h1;
    #80;
  endtask : status_rise
endmodule : tw_host_model

// ==== verif/tw_eeprom_port_tb.sv ====
module tw_eeprom_port_tb;
  import tw_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int PCYC = 2000;
  logic sys_clk = 1'h0;
  logic rst_b, width_select, select, shift_clock, serial_in, data_out, data_out_oe;
  wire  dout_w;
  int   err_total = 0;
  int   n_tests   = 0;

  assign dout_w = data_out_oe ? data_out : 1'hz;
  always #4 sys_clk = ~sys_clk;

  tw_eeprom_port #(.PROG_CYCLES(PCYC)) tw_eeprom_port_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .select(select), .shift_clock(shift_clock), .serial_in(serial_in),
    .width_select(width_select), .data_out(data_out), .data_out_oe(data_out_oe));
  tw_host_model tw_host_model_i (.select(select), .shift_clock(shift_clock),
    .serial_in(serial_in), .dout_w(dout_w));

  // ====================================
  // Compare and close
  task automatic chk_w(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk_w

  task automatic chk_b(string what, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      err_total++;
    end
  endtask : chk_b

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // ====================================
  // Shared sequences
  task automatic cmd(logic [1:0] op, logic [10:0] addr);
    tw_host_model_i.command(op, addr, width_select);
  endtask : cmd

  task automatic wr(logic [1:0] op, logic [10:0] addr, logic [15:0] d);
    cmd(op, addr);
    tw_host_model_i.send_word(d, width_select);
  endtask : wr

  task automatic busy_wait(output int n);
    n = 0;
    while (dout_w !== 1'h1 && n < PCYC + 200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask : busy_wait

  task automatic prog_status;
    int n;
    tw_host_model_i.end_frame();
    tw_host_model_i.status_rise();
    chk_b("status drive", 1'h1, data_out_oe);
    chk_b("busy level", 1'h0, data_out);
    busy_wait(n);
    chk_b("program time", 1'h1, n > PCYC - 150 && n < PCYC + 20);
    tw_host_model_i.end_frame();
    chk_b("release", 1'h0, data_out_oe);
  endtask : prog_status

  task automatic no_status;
    tw_host_model_i.end_frame();
    tw_host_model_i.status_rise();
    chk_b("no status", 1'h0, data_out_oe);
    tw_host_model_i.end_frame();
  endtask : no_status

  task automatic read_chk(logic [10:0] addr, logic [15:0] exp);
    logic        dmy;
    logic [15:0] d;
    cmd(OP_READ, addr);
    tw_host_model_i.read_word(width_select, dmy, d);
    chk_b("dummy bit", 1'h0, dmy);
    chk_w("read data", exp, d);
    tw_host_model_i.end_frame();
  endtask : read_chk

  // ====================================
  // Scenarios
  task automatic t_disabled;
    chk_b("reset oe", 1'h0, data_out_oe);
    wr(OP_WRITE, 11'h005, 16'h1111);
    no_status();
  endtask : t_disabled

  task automatic t_write;
    cmd(OP_EXT, {1'h0, EXT_EN, 8'h5A});
    tw_host_model_i.end_frame();
    wr(OP_WRITE, 11'h005, 16'hA5C3);
    prog_status();
    read_chk(11'h005, 16'hA5C3);
  endtask : t_write

  task automatic t_busy_ignore;
    int n;
    wr(OP_WRITE, 11'h005, 16'h5A3C);
    tw_host_model_i.end_frame();
    tw_host_model_i.status_rise();
    cmd(OP_READ, 11'h005);
    chk_b("busy hold", 1'h0, dout_w);
    busy_wait(n);
    chk_b("ready", 1'h1, dout_w);
    tw_host_model_i.end_frame();
    read_chk(11'h005, 16'h5A3C);
  endtask : t_busy_ignore

  task automatic t_erase;
    cmd(OP_ERASE, 11'h005);
    prog_status();
    read_chk(11'h005, ERASED_WORD);
  endtask : t_erase

  task automatic t_all;
    wr(OP_EXT, {1'h0, EXT_WALL, 8'hC3}, 16'h3C5A);
    prog_status();
    read_chk(11'h000, 16'h3C5A);
    read_chk(11'h3FF, 16'h3C5A);
    cmd(OP_EXT, {1'h0, EXT_EALL, 8'h0F});
    prog_status();
    read_chk(11'h007, ERASED_WORD);
  endtask : t_all

  task automatic t_late;
    wr(OP_WRITE, 11'h002, 16'h1234);
    tw_host_model_i.end_frame();
    repeat (PCYC + 100) @(posedge sys_clk);
    #1;
    tw_host_model_i.status_rise();
    chk_b("late status", 1'h0, data_out_oe);
    tw_host_model_i.end_frame();
  endtask : t_late

  task automatic t_bytes;
    logic        dmy;
    logic [15:0] d;
    @(posedge sys_clk);
    #1;
    width_select = 1'h0;
    read_chk(11'h005, 16'h0012);
    read_chk(11'h004, 16'h0034);
    cmd(OP_READ, 11'h004);
    tw_host_model_i.read_word(1'h0, dmy, d);
    chk_w("first byte", 16'h0034, d);
    tw_host_model_i.read_word(1'h0, dmy, d);
    chk_w("next byte", 16'h0012, d);
    tw_host_model_i.end_frame();
    @(posedge sys_clk);
    #1;
    width_select = 1'h1;
  endtask : t_bytes

  task automatic t_disable;
    cmd(OP_EXT, {1'h0, EXT_DIS, 8'hA5});
    tw_host_model_i.end_frame();
    cmd(OP_ERASE, 11'h002);
    no_status();
    read_chk(11'h002, 16'h1234);
  endtask : t_disable

  // ====================================
  // Main sequence and watchdog
  initial begin
    rst_b = 1'h0;
    width_select = 1'h1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_b = 1'h1;
    repeat (4) @(posedge sys_clk);
    #1;
    t_disabled();
    t_write();
    t_busy_ignore();
    t_erase();
    t_all();
    t_late();
    t_bytes();
    t_disable();
    close_out();
  end

  initial begin
    #600000;
    err_total++;
    close_out();
  end
endmodule : tw_eeprom_port_tb
